// [src/cwd_watchdog.v]
`timescale 1ns/1ps
`include "cwd_defines.vh"

// Behaviour
// RULE_01: watchdog is a 6-bit counter stepped by a 12-bit prescaler carry.
// RULE_02: both counters advance only on the crystal clock, never the pll.
// RULE_03: unserviced, overflow after 8176 or 262128 cycles by long select.
// RULE_04: any service write clears counter, prescaler bits 11..4, new period; one in a stop_exec, vector_fetch or stop_mode cycle keeps the counter.
// RULE_05: service read returns reset vector low byte, counters untouched.
// RULE_06: overflow drives reset pin low 32 cycles and sets cause flag.
// RULE_07: monitor mode with high voltage on reset or irq pin disables it.
// RULE_08: break state with high voltage on reset pin disables it.
// RULE_09: stop instruction clears the whole prescaler.
// RULE_10: any internal reset clears prescaler and watchdog counter.
// RULE_11: reset vector fetch clears the prescaler.
// RULE_12: disable option suppresses every watchdog reset.
// RULE_13: watchdog never raises a cpu interrupt, only a reset.
// RULE_14: watchdog keeps counting during wait mode.
// RULE_15: stop mode freezes the watchdog count and clears the prescaler.
// RULE_16: software services it right before or after stop mode.
// RULE_17: software services it from main flow, not interrupt routines.
// RULE_18: period after a service may be up to fifteen cycles short.
module cwd_watchdog
#(
	parameter SHORT_CYCLES = `CWD_SHORT_CYCLES,
	parameter LONG_CYCLES  = `CWD_LONG_CYCLES,
	parameter PULSE_CYCLES = `CWD_RST_PULSE_CYC
)
(
	// apb slave, pclk is the crystal clock
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`CWD_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	// system integration events
	input  wire                   internal_reset,
	input  wire                   vector_fetch,
	input  wire                   stop_exec,
	input  wire                   stop_mode,
	input  wire                   wait_mode,
	input  wire [7:0]             reset_vector_low,
	// mode and high-voltage detectors
	input  wire                   monitor_mode,
	input  wire                   break_state,
	input  wire                   hv_reset_pin,
	input  wire                   hv_irq_pin,
	// reset outputs
	output wire                   wd_reset_pin_n,
	output reg                    wd_reset_cause
);

	localparam PW = `CWD_PRESC_W;
	localparam WW = `CWD_WD_W;
	localparam TW = PW + WW;
	localparam [TW-1:0] SHORT_LAST = SHORT_CYCLES - 1;
	localparam [TW-1:0] LONG_LAST  = LONG_CYCLES - 1;
	localparam [`CWD_ADDR_W-1:0] A_SERVICE = {`CWD_IDX_SERVICE, 2'b00};
	localparam [`CWD_ADDR_W-1:0] A_CONFIG  = {`CWD_IDX_CONFIG, 2'b00};
	localparam [`CWD_ADDR_W-1:0] A_STATUS  = {`CWD_IDX_STATUS, 2'b00};

	reg  [PW-1:0] presc_ff;
	reg  [PW-1:0] nxt_presc;
	reg  [WW-1:0] wd_ff;
	reg  [WW-1:0] nxt_wd;
	reg  [1:0]    cfg_ff;
	reg  [1:0]    nxt_cfg;
	reg           nxt_cause;
	reg  [31:0]   nxt_prdata;
	reg           nxt_slverr;
	reg           hit;

	wire          setup;
	wire          acc;
	wire          wr;
	wire          svc_wr;
	wire          held_off;
	wire          long_sel;
	wire          cfg_disable;
	wire [TW-1:0] total;
	wire [TW-1:0] last;
	wire          overflow;
	wire          fire;
	wire          pulse_busy;
	wire          clr_all;
	wire          pulse_n;

	////////////////////////////////////////////////////////////////////////
	// bus phases; a write lands only on the completing access edge
	assign setup = psel & ~penable;
	assign acc   = psel & penable & pready;
	assign wr    = acc & pwrite;

	// any data value services; read has no side effect
	assign svc_wr = wr & (paddr == A_SERVICE); // see RULE_04 see RULE_05

	assign cfg_disable = cfg_ff[`CWD_CFG_DISABLE_BIT];
	assign long_sel    = cfg_ff[`CWD_CFG_LONG_BIT];

	// high-voltage holds keep the block cleared and silent
	assign held_off = (monitor_mode & (hv_reset_pin | hv_irq_pin)) // see RULE_07
	                | (break_state & hv_reset_pin);                // see RULE_08

	// combined count is compared, not the carry, so odd limits work
	assign total    = {wd_ff, presc_ff};
	assign last     = long_sel ? LONG_LAST : SHORT_LAST; // see RULE_03
	assign overflow = (total == last) & ~held_off & ~stop_mode;

	// disable option swallows the reset but the count still wraps
	assign fire = overflow & ~cfg_disable & ~pulse_busy; // see RULE_12

	// our own reset pulse counts as an internal reset
	assign clr_all = internal_reset | pulse_busy | held_off; // see RULE_10

	////////////////////////////////////////////////////////////////////////
	// prescaler and watchdog counter
	// pclk stands for the crystal clock; no pll clock enters here
	always @*
	begin
		nxt_presc = presc_ff;
		nxt_wd    = wd_ff;
		hit       = 1'b0;
		if (clr_all)
		begin
			nxt_presc = {PW{1'b0}};
			nxt_wd    = {WW{1'b0}};
		end
		else if (stop_mode)
		begin
			// crystal gated off: count frozen, prescaler cleared
			nxt_presc = {PW{1'b0}}; // see RULE_15
		end
		else if (overflow)
		begin
			nxt_presc = {PW{1'b0}};
			nxt_wd    = {WW{1'b0}};
			hit       = 1'b1;
		end
		else if (stop_exec | vector_fetch)
		begin
			nxt_presc = {PW{1'b0}}; // see RULE_09 see RULE_11
		end
		else if (svc_wr)
		begin
			// bits 3..0 survive, so next period may run short
			nxt_wd    = {WW{1'b0}};                         // see RULE_04
			nxt_presc = {{(PW-4){1'b0}}, presc_ff[3:0]};    // see RULE_18
		end
		else
		begin
			// wait mode does not stop the count
			nxt_presc = presc_ff + 1'b1; // see RULE_02 see RULE_14
			if (presc_ff == {PW{1'b1}})
				nxt_wd = wd_ff + 1'b1; // see RULE_01
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			presc_ff <= {PW{1'b0}};
			wd_ff    <= {WW{1'b0}};
		end
		else
		begin
			presc_ff <= nxt_presc;
			wd_ff    <= nxt_wd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset pin pulse; no interrupt output exists at all
	cwd_pulse
	#(
		.WIDTH  (6),
		.CYCLES (PULSE_CYCLES)
	)
	u_pulse
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (fire),   // see RULE_06 see RULE_13
		.pulse_n_ff (pulse_n),
		.busy_ff    (pulse_busy)
	);

	assign wd_reset_pin_n = pulse_n;

	////////////////////////////////////////////////////////////////////////
	// config and cause flag; the setting event wins over a clear
	always @*
	begin
		nxt_cfg   = cfg_ff;
		nxt_cause = wd_reset_cause;
		if (wr & (paddr == A_CONFIG))
			nxt_cfg = pwdata[1:0];
		if (wr & (paddr == A_STATUS) & pwdata[`CWD_ST_CAUSE_BIT])
			nxt_cause = 1'b0;
		if (fire)
			nxt_cause = 1'b1; // see RULE_06
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_ff         <= `CWD_CFG_RESET;
			wd_reset_cause <= 1'b0;
		end
		else
		begin
			cfg_ff         <= nxt_cfg;
			wd_reset_cause <= nxt_cause;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux, captured in the setup cycle so data comes from a flop
	always @*
	begin
		nxt_prdata = 32'h0000_0000;
		nxt_slverr = 1'b0;
		case (paddr)
			A_SERVICE:
				nxt_prdata[7:0] = reset_vector_low; // see RULE_05
			A_CONFIG:
				nxt_prdata[1:0] = cfg_ff;
			A_STATUS:
			begin
				nxt_prdata[`CWD_ST_CAUSE_BIT] = wd_reset_cause;
				nxt_prdata[`CWD_ST_COUNT_LSB +: WW] = wd_ff;
				nxt_prdata[`CWD_ST_HELD_BIT] = held_off;
			end
			default:
				nxt_slverr = 1'b1;
		endcase
	end

	// one wait-free answer: pready rises in the first access cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & nxt_slverr;
			if (setup & ~pwrite)
				prdata <= nxt_prdata;
		end
	end

endmodule

// [src/cwd_defines.vh]
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH

// register indices; byte address is four times the index
`define CWD_IDX_SERVICE     16'hffff
`define CWD_IDX_CONFIG      16'h001f
`define CWD_IDX_STATUS      16'h0001
`define CWD_ADDR_W          18

// config register fields
`define CWD_CFG_DISABLE_BIT 0
`define CWD_CFG_LONG_BIT    1
`define CWD_CFG_RESET       2'h0

// status register fields
`define CWD_ST_CAUSE_BIT    0
`define CWD_ST_COUNT_LSB    8
`define CWD_ST_HELD_BIT     16

// counter widths
`define CWD_PRESC_W         12
`define CWD_WD_W            6

// timing, in crystal clock cycles
`define CWD_SHORT_CYCLES    8176
`define CWD_LONG_CYCLES     262128
`define CWD_RST_PULSE_CYC   32

`endif

// [src/cwd_pulse.v]
`timescale 1ns/1ps
`include "cwd_defines.vh"

// stretches a one-cycle trigger into a low pulse of fixed length
module cwd_pulse
#(
	parameter WIDTH  = 6,
	parameter CYCLES = `CWD_RST_PULSE_CYC
)
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// trigger and pulse
	input  wire        start,
	output reg         pulse_n_ff,
	output reg         busy_ff
);

	localparam [WIDTH-1:0] LAST = CYCLES - 1;

	reg  [WIDTH-1:0] cnt_ff;
	reg  [WIDTH-1:0] nxt_cnt;
	reg              nxt_busy;

	////////////////////////////////////////////////////////////////////////
	// length counter; a retrigger while busy is ignored
	always @*
	begin
		nxt_cnt  = cnt_ff;
		nxt_busy = busy_ff;
		if (busy_ff)
		begin
			if (cnt_ff == LAST)
			begin
				nxt_busy = 1'b0;
				nxt_cnt  = {WIDTH{1'b0}};
			end
			else
				nxt_cnt = cnt_ff + 1'b1;
		end
		else if (start)
		begin
			nxt_busy = 1'b1;
			nxt_cnt  = {WIDTH{1'b0}};
		end
	end

	// pin is low exactly while busy
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff     <= {WIDTH{1'b0}};
			busy_ff    <= 1'b0;
			pulse_n_ff <= 1'b1;
		end
		else
		begin
			cnt_ff     <= nxt_cnt;
			busy_ff    <= nxt_busy;
			pulse_n_ff <= ~nxt_busy;
		end
	end

endmodule

// [tb/cwd_chk.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// port-level checks; pulse length counted in a helper
module cwd_chk
#(
	parameter PULSE_CYCLES = 4
)
(
	// clock, reset and apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [17:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// events and modes
	input wire        internal_reset,
	input wire        stop_mode,
	input wire        monitor_mode,
	input wire        break_state,
	input wire        hv_reset_pin,
	input wire        hv_irq_pin,
	input wire [7:0]  reset_vector_low,
	// reset outputs
	input wire        wd_reset_pin_n,
	input wire        wd_reset_cause
);
	reg  [7:0] low_ff;
	wire       held;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// any of these must stop a fire two edges later
	assign held = internal_reset | stop_mode | break_state & hv_reset_pin
		| monitor_mode & (hv_reset_pin | hv_irq_pin);
	// counts low cycles of the reset pin
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			low_ff <= 8'h00;
		else
			low_ff <= wd_reset_pin_n ? 8'h00 : low_ff + 8'h01;
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned not refused");
	a_svc_read: assert property (pready && !pwrite && paddr == 18'h3fffc
		|-> prdata == {24'h000000, reset_vector_low}) else $error("bad vector");
	a_pulse_len: assert property ($rose(wd_reset_pin_n) |->
		low_ff == PULSE_CYCLES) else $error("reset pulse length");
	a_cause_pin: assert property ($rose(wd_reset_cause) |->
		$fell(wd_reset_pin_n)) else $error("cause without pulse");
	a_no_fire_held: assert property ($fell(wd_reset_pin_n) |->
		!$past(held, 2)) else $error("fire while held");
	a_cause_sticky: assert property (wd_reset_cause && !(pready && pwrite
		&& paddr == 18'h00004) |=> wd_reset_cause) else $error("cause lost");
	c_fire: cover property ($fell(wd_reset_pin_n));
	c_err: cover property (pready && pslverr);
	c_held: cover property (held [*8]);
endmodule
bind cwd_watchdog cwd_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.internal_reset(internal_reset), .stop_mode(stop_mode),
	.monitor_mode(monitor_mode), .break_state(break_state),
	.hv_reset_pin(hv_reset_pin), .hv_irq_pin(hv_irq_pin),
	.reset_vector_low(reset_vector_low), .wd_reset_pin_n(wd_reset_pin_n),
	.wd_reset_cause(wd_reset_cause));

// [tb/cwd_cpu_model.sv]
`timescale 1ns/1ps
// cpu side: fetches the reset vector once the pin is let go
module cwd_cpu_model
#(
	parameter VEC = 8'h5a // arbitrary vector byte
)
(
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// reset pin in, fetch out
	input  wire       wd_reset_pin_n,
	output reg        vector_fetch,
	output wire [7:0] reset_vector_low
);
	reg pin_ff;
	assign reset_vector_low = VEC;
	// one-cycle fetch on the edge after the pin rises
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pin_ff       <= 1'b1;
			vector_fetch <= 1'b0;
		end
		else
		begin
			pin_ff       <= wd_reset_pin_n;
			vector_fetch <= wd_reset_pin_n & ~pin_ff;
		end
endmodule

// [tb/tb_cwd_watchdog.sv]
`timescale 1ns/1ps
module tb_cwd_watchdog;
	localparam SVC = 18'h3fffc;
	localparam CFG = 18'h0007c;
	localparam ST  = 18'h00004;
	logic        pclk, presetn, psel, penable, pwrite, internal_reset;
	logic        stop_exec, stop_mode, wait_mode, monitor_mode, break_state;
	logic        hv_reset_pin, hv_irq_pin, pready, pslverr, er;
	logic        wd_reset_pin_n, wd_reset_cause, vector_fetch;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  reset_vector_low;
	int          n_fail, n_checks, n_pulses;
	always #5 pclk = ~pclk;
	always @(negedge wd_reset_pin_n) n_pulses++;
	// short counts keep the run brief
	cwd_watchdog #(.SHORT_CYCLES(40), .LONG_CYCLES(80), .PULSE_CYCLES(4)) i_dut
	(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .internal_reset(internal_reset),
	.vector_fetch(vector_fetch), .stop_exec(stop_exec), .stop_mode(stop_mode),
	.wait_mode(wait_mode), .reset_vector_low(reset_vector_low),
	.monitor_mode(monitor_mode), .break_state(break_state),
	.hv_reset_pin(hv_reset_pin), .hv_irq_pin(hv_irq_pin),
	.wd_reset_pin_n(wd_reset_pin_n), .wd_reset_cause(wd_reset_cause));
	cwd_cpu_model i_cpu (.pclk(pclk), .presetn(presetn),
	.wd_reset_pin_n(wd_reset_pin_n), .vector_fetch(vector_fetch),
	.reset_vector_low(reset_vector_low));
	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request held until ready is seen high at a rising edge
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1)
			n_fail++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input int which);
		@(posedge pclk);
		if (which == 0) internal_reset <= 1'b1; else stop_exec <= 1'b1;
		@(posedge pclk);
		internal_reset <= 1'b0;
		stop_exec      <= 1'b0;
	endtask
	task t_regs;
		apb(0, SVC, 0); chk(rd, {24'h0, reset_vector_low});
		apb(0, ST, 0); chk(rd, 0);
		apb(0, CFG, 0); chk(rd, 0);
		apb(1, 18'h00102, 1); chk(er, 1);
		apb(0, 18'h00200, 0); chk(er, 1);
		$display("regs done");
	endtask
	task t_period(input logic lng, input int lim);
		int n;
		apb(1, CFG, {30'h0, lng, 1'b0});
		pulse(0);
		for (n = 0; n < 400 && wd_reset_pin_n === 1'b1; n++) @(negedge pclk);
		chk(n >= lim && n <= lim + 3, 1);
		for (n = 0; n < 50 && wd_reset_pin_n !== 1'b1; n++) @(negedge pclk);
		chk(n, 4);
		apb(0, ST, 0); chk(rd[0], 1);
		apb(1, ST, 1);
		$display("period done");
	endtask
	// mode 0 service write, 1 service read, 2 stop instruction
	task t_keep(input int mode, input logic fire);
		int i, p0;
		wait_mode <= 1'b1;
		pulse(0);
		p0 = n_pulses;
		for (i = 0; i < 12; i++)
		begin
			repeat (12) @(posedge pclk);
			if (mode == 2) pulse(1); else apb(mode == 0, SVC, i);
		end
		chk(n_pulses != p0, fire);
		wait_mode <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(1, ST, 1);
		$display("keep done");
	endtask
	// c: disable, stop, monitor, break, hv reset pin, hv irq pin
	task t_hold(input logic [5:0] c, input logic fire);
		int p0;
		apb(1, CFG, {31'h0, c[5]});
		apb(1, SVC, 0);
		{stop_mode, monitor_mode, break_state, hv_reset_pin, hv_irq_pin} <= c[4:0];
		pulse(0);
		p0 = n_pulses;
		repeat (200) @(posedge pclk);
		chk(n_pulses != p0, fire);
		{stop_mode, monitor_mode, break_state, hv_reset_pin, hv_irq_pin} <= 0;
		apb(1, CFG, 0);
		repeat (10) @(posedge pclk);
		apb(1, ST, 1);
		$display("hold done");
	endtask
	task wrap_up;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, internal_reset} = 0;
		{stop_exec, stop_mode, wait_mode, monitor_mode, break_state} = 0;
		{hv_reset_pin, hv_irq_pin, paddr, pwdata} = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_period(0, 40);
		t_period(1, 80);
		t_keep(0, 0);
		t_keep(1, 1);
		t_keep(2, 0);
		t_hold(6'b001010, 0);
		t_hold(6'b001001, 0);
		t_hold(6'b000110, 0);
		t_hold(6'b010000, 0);
		t_hold(6'b100000, 0);
		t_hold(6'b000101, 1);
		wrap_up;
	end
	// guard against a hang, far beyond the few thousand cycles used
	initial
	begin
		#200000;
		n_fail++;
		wrap_up;
	end
endmodule
